// ===== core/sfb_defines.vh
// constants for the status frame builder
// assumes inclusion by bare name from core/ design files
`ifndef SFB_DEFINES_VH
`define SFB_DEFINES_VH
`define SFB_START_BYTE 8'h7E
`define SFB_TYPE_COND 8'h8A
`define SFB_TYPE_TXRES 8'h8B
`define SFB_LEN_COND 16'h0002
`define SFB_LEN_TXRES 16'h0007
`define SFB_CKS_BASE 8'hFF
`define SFB_RSVD_FIELD 16'hFFFE
`define SFB_CST_HW_RESET 8'h00
`define SFB_CST_WDOG_RESET 8'h01
`define SFB_CST_JOINED 8'h02
`define SFB_CST_LEFT 8'h03
`define SFB_CST_WOKE 8'h0B
`define SFB_CST_SLEEP 8'h0C
`define SFB_CST_VOLT 8'h0D
`define SFB_CST_ID_CHANGED 8'h3F
`define SFB_CST_NET_WDOG 8'h42
`define SFB_CST_STACK_ERR_MIN 8'h80
`define SFB_DLV_SUCCESS 8'h00
`define SFB_DLV_MAC_ACK 8'h01
`define SFB_DLV_CCA 8'h02
`define SFB_DLV_NET_ACK 8'h21
`define SFB_DLV_NO_ROUTE 8'h25
`define SFB_DLV_RES_INT 8'h31
`define SFB_DLV_RES_BUF 8'h32
`define SFB_DLV_TOO_LARGE 8'h74
`define SFB_DSC_NONE 8'h00
`define SFB_DSC_ROUTE 8'h02
`define SFB_OFS_TYPE 4'h3
`define SFB_OFS_CKS_COND 4'h5
`define SFB_OFS_CKS_TXRES 4'hA
`define SFB_FIFO_DEPTH 4
`define SFB_FIFO_AW 2
`endif

// ===== core/sfb_fifo.v
// byte fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module sfb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;
  assign in_ready_o = (count_ff != DEPTH[AW:0]);
  assign out_valid_o = (count_ff != {(AW+1){1'b0}});
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ===== core/sfb_builder.v
// status frame builder: condition-report and transmit-result frames as a byte stream
// assumes event inputs on clk_sys_i; the byte sink applies ready/valid back-pressure
`timescale 1ns/1ps
`include "sfb_defines.vh"

module sfb_builder (
  input wire clk_sys_i,
  input wire rst_i,
  input wire cond_valid_i,
  output wire cond_ready_o,
  input wire [3:0] cond_cause_i,
  input wire [6:0] cond_stack_err_i,
  input wire txres_valid_i,
  output wire txres_ready_o,
  input wire [7:0] txres_frame_id_i,
  input wire [7:0] txres_retries_i,
  input wire [3:0] txres_result_i,
  input wire txres_broadcast_i,
  input wire txres_discovery_i,
  output wire byte_valid_o,
  input wire byte_ready_i,
  output wire [7:0] byte_data_o,
  output wire byte_last_o,
  output wire busy_o,
  output wire [7:0] txres_dropped_o
);
  // ****************************************
  // cause and result encodings
  // ****************************************
  localparam [3:0] CAUSE_HW_RESET = 4'h0;
  localparam [3:0] CAUSE_WDOG = 4'h1;
  localparam [3:0] CAUSE_JOIN = 4'h2;
  localparam [3:0] CAUSE_LEAVE = 4'h3;
  localparam [3:0] CAUSE_WOKE = 4'h4;
  localparam [3:0] CAUSE_SLEEP = 4'h5;
  localparam [3:0] CAUSE_VOLT = 4'h6;
  localparam [3:0] CAUSE_NET_WDOG = 4'h7;
  localparam [3:0] CAUSE_ID_CHG = 4'h8;
  localparam [3:0] CAUSE_STACK = 4'h9;
  localparam [3:0] RES_SUCCESS = 4'h0;
  localparam [3:0] RES_MAC_ACK = 4'h1;
  localparam [3:0] RES_CCA = 4'h2;
  localparam [3:0] RES_NET_ACK = 4'h3;
  localparam [3:0] RES_NO_ROUTE = 4'h4;
  localparam [3:0] RES_INT = 4'h5;
  localparam [3:0] RES_BUF = 4'h6;
  localparam [3:0] RES_TOO_LARGE = 4'h7;

  // ****************************************
  // state
  // ****************************************
  localparam [1:0] ST_BOOT = 2'd0;
  localparam [1:0] ST_IDLE = 2'd1;
  localparam [1:0] ST_SEND = 2'd2;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg kind_ff;
  reg [3:0] idx_ff;
  reg [3:0] nxt_idx;
  reg [7:0] f4_ff;
  reg [7:0] f7_ff;
  reg [7:0] f8_ff;
  reg [7:0] f9_ff;
  reg [7:0] sum_ff;
  reg [7:0] dropped_ff;
  reg [7:0] cond_code;
  reg [7:0] dlv_code;
  reg [7:0] cur_byte;
  wire [3:0] last_idx;
  wire fifo_ready;
  wire emit;
  wire take_cond;
  wire take_tx;
  wire tx_drop;
  wire [15:0] cur_len;
  wire [15:0] rsvd_field;

  // ****************************************
  // code mapping
  // ****************************************
  always @* begin
    cond_code = `SFB_CST_HW_RESET;
    case (cond_cause_i)
      CAUSE_HW_RESET: cond_code = `SFB_CST_HW_RESET;
      CAUSE_WDOG: cond_code = `SFB_CST_WDOG_RESET;
      CAUSE_JOIN: cond_code = `SFB_CST_JOINED;
      CAUSE_LEAVE: cond_code = `SFB_CST_LEFT;
      CAUSE_WOKE: cond_code = `SFB_CST_WOKE;
      CAUSE_SLEEP: cond_code = `SFB_CST_SLEEP;
      CAUSE_VOLT: cond_code = `SFB_CST_VOLT;
      CAUSE_NET_WDOG: cond_code = `SFB_CST_NET_WDOG;
      CAUSE_ID_CHG: cond_code = `SFB_CST_ID_CHANGED;
      CAUSE_STACK: cond_code = `SFB_CST_STACK_ERR_MIN | {1'b0, cond_stack_err_i};
      default: cond_code = `SFB_CST_HW_RESET;
    endcase
  end

  always @* begin
    dlv_code = `SFB_DLV_SUCCESS;
    if (txres_broadcast_i) begin
      dlv_code = `SFB_DLV_SUCCESS;
    end else begin
      case (txres_result_i)
        RES_SUCCESS: dlv_code = `SFB_DLV_SUCCESS;
        RES_MAC_ACK: dlv_code = `SFB_DLV_MAC_ACK;
        RES_CCA: dlv_code = `SFB_DLV_CCA;
        RES_NET_ACK: dlv_code = `SFB_DLV_NET_ACK;
        RES_NO_ROUTE: dlv_code = `SFB_DLV_NO_ROUTE;
        RES_INT: dlv_code = `SFB_DLV_RES_INT;
        RES_BUF: dlv_code = `SFB_DLV_RES_BUF;
        RES_TOO_LARGE: dlv_code = `SFB_DLV_TOO_LARGE;
        default: dlv_code = `SFB_DLV_RES_INT;
      endcase
    end
  end

  // ****************************************
  // request acceptance
  // ****************************************
  // condition reports win over transmit results
  assign take_cond = (state_ff == ST_IDLE) && cond_valid_i;
  assign take_tx = (state_ff == ST_IDLE) && !cond_valid_i && txres_valid_i;
  assign tx_drop = take_tx && (txres_frame_id_i == 8'h00);
  assign cond_ready_o = (state_ff == ST_IDLE);
  assign txres_ready_o = (state_ff == ST_IDLE) && !cond_valid_i;
  assign busy_o = (state_ff != ST_IDLE);
  assign txres_dropped_o = dropped_ff;

  // ****************************************
  // byte selection
  // ****************************************
  assign last_idx = kind_ff ? `SFB_OFS_CKS_TXRES : `SFB_OFS_CKS_COND;
  assign cur_len = kind_ff ? `SFB_LEN_TXRES : `SFB_LEN_COND;
  assign rsvd_field = `SFB_RSVD_FIELD;

  always @* begin
    cur_byte = 8'h00;
    case (idx_ff)
      4'h0: cur_byte = `SFB_START_BYTE;
      4'h1: cur_byte = cur_len[15:8];
      4'h2: cur_byte = cur_len[7:0];
      4'h3: cur_byte = kind_ff ? `SFB_TYPE_TXRES : `SFB_TYPE_COND;
      4'h4: cur_byte = f4_ff;
      4'h5: cur_byte = kind_ff ? rsvd_field[15:8] : `SFB_CKS_BASE - sum_ff;
      4'h6: cur_byte = rsvd_field[7:0];
      4'h7: cur_byte = f7_ff;
      4'h8: cur_byte = f8_ff;
      4'h9: cur_byte = f9_ff;
      4'hA: cur_byte = `SFB_CKS_BASE - sum_ff;
      default: cur_byte = 8'h00;
    endcase
  end

  assign emit = (state_ff == ST_SEND) && fifo_ready;

  // ****************************************
  // sequencer
  // ****************************************
  always @* begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    case (state_ff)
      ST_BOOT: begin
        nxt_state = ST_SEND;
        nxt_idx = 4'h0;
      end
      ST_IDLE: begin
        if (take_cond || (take_tx && !tx_drop)) begin
          nxt_state = ST_SEND;
          nxt_idx = 4'h0;
        end
      end
      ST_SEND: begin
        if (emit) begin
          if (idx_ff == last_idx) begin
            nxt_state = ST_IDLE;
            nxt_idx = 4'h0;
          end else begin
            nxt_idx = idx_ff + 4'h1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_idx = 4'h0;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_ff <= ST_BOOT;
      idx_ff <= 4'h0;
      kind_ff <= 1'b0;
      f4_ff <= 8'h00;
      f7_ff <= 8'h00;
      f8_ff <= 8'h00;
      f9_ff <= 8'h00;
      sum_ff <= 8'h00;
      dropped_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      if (state_ff == ST_BOOT) begin
        kind_ff <= 1'b0;
        f4_ff <= `SFB_CST_HW_RESET;
      end else if (take_cond) begin
        kind_ff <= 1'b0;
        f4_ff <= cond_code;
      end else if (take_tx && !tx_drop) begin
        kind_ff <= 1'b1;
        f4_ff <= txres_frame_id_i;
        f7_ff <= txres_retries_i;
        f8_ff <= dlv_code;
        f9_ff <= txres_discovery_i ? `SFB_DSC_ROUTE : `SFB_DSC_NONE;
      end
      if (tx_drop) begin
        dropped_ff <= dropped_ff + 8'h01;
      end
      if (state_ff != ST_SEND) begin
        sum_ff <= 8'h00;
      end else if (emit && idx_ff >= `SFB_OFS_TYPE && idx_ff != last_idx) begin
        sum_ff <= sum_ff + cur_byte;
      end
    end
  end

  // ****************************************
  // output buffer
  // ****************************************
  wire [8:0] fifo_out;
  wire fifo_valid;
  wire fifo_take;
  reg out_valid_ff;
  reg [7:0] out_data_ff;
  reg out_last_ff;
  // output stage refills whenever empty or being drained
  assign fifo_take = !out_valid_ff || byte_ready_i;
  sfb_fifo #(
    .WIDTH(9),
    .DEPTH(`SFB_FIFO_DEPTH),
    .AW(`SFB_FIFO_AW)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(state_ff == ST_SEND),
    .in_ready_o(fifo_ready),
    .in_data_i({idx_ff == last_idx, cur_byte}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_take),
    .out_data_o(fifo_out)
  );

  // ****************************************
  // output register
  // ****************************************
  // byte stream leaves the block from flip-flops
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= 8'h00;
      out_last_ff <= 1'b0;
    end else if (fifo_valid && fifo_take) begin
      out_valid_ff <= 1'b1;
      out_data_ff <= fifo_out[7:0];
      out_last_ff <= fifo_out[8];
    end else if (byte_ready_i) begin
      out_valid_ff <= 1'b0;
    end
  end
  assign byte_valid_o = out_valid_ff;
  assign byte_data_o = out_data_ff;
  assign byte_last_o = out_last_ff;
endmodule

// ===== sim/sfb_builder_checker.sv
// checker for the status frame builder byte stream
// assumes the ports of sfb_builder, one clock domain
`timescale 1ns/1ps
module sfb_builder_checker (
  input wire clk_sys_i,
  input wire rst_i,
  input wire cond_valid_i,
  input wire cond_ready_o,
  input wire [3:0] cond_cause_i,
  input wire [6:0] cond_stack_err_i,
  input wire txres_valid_i,
  input wire txres_ready_o,
  input wire [7:0] txres_frame_id_i,
  input wire [7:0] txres_retries_i,
  input wire [3:0] txres_result_i,
  input wire txres_broadcast_i,
  input wire txres_discovery_i,
  input wire byte_valid_o,
  input wire byte_ready_i,
  input wire [7:0] byte_data_o,
  input wire byte_last_o,
  input wire busy_o,
  input wire [7:0] txres_dropped_o
);
  // ****
  // frame position tracking
  // ****
  wire hs = byte_valid_o && byte_ready_i;
  reg [3:0] idx_ff;
  reg [7:0] typ_ff;
  reg [7:0] sum_ff;
  reg boot_ff;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      idx_ff <= 4'h0;
      typ_ff <= 8'h00;
      sum_ff <= 8'h00;
      boot_ff <= 1'b1;
    end else if (hs) begin
      idx_ff <= byte_last_o ? 4'h0 : idx_ff + 4'h1;
      typ_ff <= (idx_ff == 4'h3) ? byte_data_o : typ_ff;
      sum_ff <= (idx_ff < 4'h3) ? 8'h00 : sum_ff + byte_data_o;
      boot_ff <= boot_ff && !byte_last_o;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_start_byte: assert property (byte_valid_o && idx_ff == 4'h0 |-> byte_data_o == 8'h7E)
    else $error("frame start byte wrong");
  chk_data_hold: assert property (byte_valid_o && !byte_ready_i |=>
    byte_valid_o && $stable(byte_data_o) && $stable(byte_last_o)) else $error("byte not held");
  chk_len_field: assert property (byte_valid_o && idx_ff[3:1] == 3'h0 && idx_ff[0] |->
    byte_data_o == 8'h00) else $error("length high byte wrong");
  chk_frame_end: assert property (hs && byte_last_o |->
    (typ_ff == 8'h8A && idx_ff == 4'h5) || (typ_ff == 8'h8B && idx_ff == 4'hA))
    else $error("frame length wrong");
  chk_checksum_byte: assert property (byte_valid_o && byte_last_o |->
    8'(sum_ff + byte_data_o) == 8'hFF) else $error("checksum wrong");
  chk_boot_frame: assert property (byte_valid_o && boot_ff && idx_ff inside {4'h3, 4'h4} |->
    byte_data_o == (idx_ff[2] ? 8'h00 : 8'h8A)) else $error("boot frame wrong");
  chk_type_byte: assert property (byte_valid_o && idx_ff == 4'h3 |->
    byte_data_o inside {8'h8A, 8'h8B}) else $error("frame type wrong");
  chk_reserved_field: assert property (byte_valid_o && typ_ff == 8'h8B &&
    idx_ff inside {4'h5, 4'h6} |-> byte_data_o == (idx_ff[0] ? 8'hFF : 8'hFE))
    else $error("reserved field wrong");
  chk_drop_count: assert property (txres_valid_i && txres_ready_o && txres_frame_id_i == 8'h00
    |=> txres_dropped_o == $past(txres_dropped_o) + 8'h01) else $error("drop count wrong");
  cover property (hs && byte_last_o && typ_ff == 8'h8A);
  cover property (hs && byte_last_o && typ_ff == 8'h8B);
  cover property (byte_valid_o && !byte_ready_i && busy_o);
endmodule
bind sfb_builder sfb_builder_checker chk (.clk_sys_i, .rst_i, .cond_valid_i, .cond_ready_o,
  .cond_cause_i, .cond_stack_err_i, .txres_valid_i, .txres_ready_o, .txres_frame_id_i,
  .txres_retries_i, .txres_result_i, .txres_broadcast_i, .txres_discovery_i, .byte_valid_o,
  .byte_ready_i, .byte_data_o, .byte_last_o, .busy_o, .txres_dropped_o);

// ===== sim/sfb_host_sink.sv
// host-side byte sink model for the status frame builder
// assumes one clock; stall controls come from the bench
`timescale 1ns/1ps
module sfb_host_sink (
  input wire clk_sys_i,
  input wire rst_i,
  input wire hold_i,
  input wire slow_i,
  input wire byte_valid_i,
  input wire [7:0] byte_data_i,
  input wire byte_last_i,
  output wire byte_ready_o
);
  // ****
  // receive and checksum
  // ****
  logic [7:0] q[$];
  logic [7:0] sum_ff = 8'h00;
  logic [3:0] idx_ff = 4'h0;
  logic tog_ff = 1'b0;
  int bad_cnt = 0;
  assign byte_ready_o = !hold_i && !(slow_i && tog_ff);
  always @(posedge clk_sys_i) begin
    tog_ff <= !tog_ff;
    if (rst_i) begin
      idx_ff <= 4'h0;
    end else if (byte_valid_i && byte_ready_o) begin
      q.push_back(byte_data_i);
      idx_ff <= byte_last_i ? 4'h0 : idx_ff + 4'h1;
      sum_ff <= (idx_ff < 4'h3) ? 8'h00 : sum_ff + byte_data_i;
      if (byte_last_i && 8'(sum_ff + byte_data_i) != 8'hFF) bad_cnt <= bad_cnt + 1;
    end
  end
endmodule

// ===== sim/sfb_builder_tb.sv
// testbench for the status frame builder
// assumes sfb_builder, the sink model and the bound checker
`timescale 1ns/1ps
module sfb_builder_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic cond_valid_i = 1'b0;
  logic [3:0] cond_cause_i = 4'h0;
  logic [6:0] cond_stack_err_i = 7'h00;
  logic txres_valid_i = 1'b0;
  logic [7:0] txres_frame_id_i = 8'h00;
  logic [7:0] txres_retries_i = 8'h00;
  logic [3:0] txres_result_i = 4'h0;
  logic txres_broadcast_i = 1'b0;
  logic txres_discovery_i = 1'b0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  wire cond_ready_o, txres_ready_o, byte_valid_o, byte_ready_i, byte_last_o, busy_o;
  wire [7:0] byte_data_o, txres_dropped_o;
  int error_cnt = 0;
  int n_tests = 0;
  logic [7:0] e[11];
  sfb_builder uut (.clk_sys_i, .rst_i, .cond_valid_i, .cond_ready_o, .cond_cause_i,
    .cond_stack_err_i, .txres_valid_i, .txres_ready_o, .txres_frame_id_i, .txres_retries_i,
    .txres_result_i, .txres_broadcast_i, .txres_discovery_i, .byte_valid_o, .byte_ready_i,
    .byte_data_o, .byte_last_o, .busy_o, .txres_dropped_o);
  sfb_host_sink host (.clk_sys_i, .rst_i, .hold_i(hold), .slow_i(slow),
    .byte_valid_i(byte_valid_o), .byte_data_i(byte_data_o), .byte_last_i(byte_last_o),
    .byte_ready_o(byte_ready_i));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // ****
  // helpers
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic head(input logic [7:0] len, input logic [7:0] typ);
    e[0] = 8'h7E;
    e[1] = 8'h00;
    e[2] = len;
    e[3] = typ;
  endtask
  task automatic frame(input int n);
    int k;
    e[n-1] = 8'hFF;
    for (k = 3; k < n - 1; k++) e[n-1] = e[n-1] - e[k];
    k = 0;
    while (host.q.size() < n && k < 400) begin
      @(posedge clk_sys_i);
      k++;
    end
    for (k = 0; k < n; k++) chk(host.q.size() > k ? host.q[k] : 8'hxx, e[k]);
    repeat (n) if (host.q.size() > 0) void'(host.q.pop_front());
  endtask
  task automatic cond(input logic [3:0] c, input logic [6:0] se);
    @(posedge clk_sys_i);
    cond_valid_i <= 1'b1;
    cond_cause_i <= c;
    cond_stack_err_i <= se;
    @(negedge clk_sys_i);
    while (!cond_ready_o) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    cond_valid_i <= 1'b0;
  endtask
  task automatic txres(input logic [7:0] id, input logic [3:0] r, input logic bc, input logic d);
    @(posedge clk_sys_i);
    txres_valid_i <= 1'b1;
    txres_frame_id_i <= id;
    txres_retries_i <= 8'hF8 + r;
    txres_result_i <= r;
    txres_broadcast_i <= bc;
    txres_discovery_i <= d;
    @(negedge clk_sys_i);
    while (!txres_ready_o) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    txres_valid_i <= 1'b0;
  endtask
  task automatic txexp(input logic [7:0] id, input logic [3:0] r, input logic [7:0] dl);
    head(8'h07, 8'h8B);
    e[4] = id;
    e[5] = 8'hFF;
    e[6] = 8'hFE;
    e[7] = 8'hF8 + r;
    e[8] = dl;
    e[9] = r[0] ? 8'h02 : 8'h00;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_cond();
    logic [7:0] cd[10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0B, 8'h0C, 8'h0D, 8'h42, 8'h3F, 8'hFF};
    head(8'h02, 8'h8A);
    e[4] = 8'h00;
    frame(6);
    for (int i = 0; i < 10; i++) begin
      cond(i, 7'h7F);
      e[4] = cd[i];
      frame(6);
    end
    cond(4'h9, 7'h00);
    e[4] = 8'h80;
    frame(6);
    cond(4'hC, 7'h7F);
    e[4] = 8'h00;
    frame(6);
  endtask
  task automatic t_fill();
    hold <= 1'b1;
    cond(4'h1, 7'h00);
    repeat (20) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({6'h00, busy_o, byte_valid_o}, 8'h03);
    chk({7'h00, cond_ready_o}, 8'h00);
    chk({7'h00, txres_ready_o}, 8'h00);
    @(posedge clk_sys_i);
    hold <= 1'b0;
    e[4] = 8'h01;
    frame(6);
  endtask
  task automatic t_txres();
    logic [7:0] dl[8] = '{8'h00, 8'h01, 8'h02, 8'h21, 8'h25, 8'h31, 8'h32, 8'h74};
    slow <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      txres(8'hA0 + i, i, 1'b0, i[0]);
      txexp(8'hA0 + i, i, dl[i]);
      frame(11);
    end
    txres(8'hA8, 4'hF, 1'b0, 1'b1);
    txexp(8'hA8, 4'hF, 8'h31);
    frame(11);
  endtask
  task automatic t_prio();
    @(posedge clk_sys_i);
    txres_valid_i <= 1'b1;
    txres_frame_id_i <= 8'h33;
    txres_retries_i <= 8'hFB;
    txres_result_i <= 4'h3;
    txres_broadcast_i <= 1'b0;
    txres_discovery_i <= 1'b1;
    cond_valid_i <= 1'b1;
    cond_cause_i <= 4'h2;
    cond_stack_err_i <= 7'h00;
    @(negedge clk_sys_i);
    while (!cond_ready_o) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    cond_valid_i <= 1'b0;
    @(negedge clk_sys_i);
    while (!txres_ready_o) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    txres_valid_i <= 1'b0;
    head(8'h02, 8'h8A);
    e[4] = 8'h02;
    frame(6);
    txexp(8'h33, 4'h3, 8'h21);
    frame(11);
  endtask
  task automatic t_drop();
    logic [7:0] cnt;
    cnt = txres_dropped_o;
    txres(8'h00, 4'h2, 1'b0, 1'b0);
    @(negedge clk_sys_i);
    chk(txres_dropped_o, cnt + 8'h01);
    txres(8'h05, 4'h1, 1'b1, 1'b1);
    txexp(8'h05, 4'h1, 8'h00);
    frame(11);
    chk(host.bad_cnt[7:0], 8'h00);
  endtask
  task automatic results();
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_cond();
    t_fill();
    t_txres();
    t_prio();
    t_drop();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    results();
  end
endmodule
